// ===== src/fas_pkg.sv
package fas_pkg;

  // ---------------------------------------------------------------
  // register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_AUX_UNDER_HOT_ALERT   = 8'h0d;
  localparam logic [7:0]  ADDR_CMP_CELL_OVER_ALERT   = 8'h0e;
  localparam logic [7:0]  ADDR_CMP_CELL_UNDER_ALERT  = 8'h0f;
  localparam logic [7:0]  ADDR_AUX_UNDER_ALERT_EN    = 8'h20;
  localparam logic [7:0]  ADDR_CELL_OVER_ALERT_EN    = 8'h21;
  localparam logic [7:0]  ADDR_CELL_UNDER_ALERT_EN   = 8'h22;
  localparam logic [7:0]  ADDR_IRQ_STATUS            = 8'h23;
  localparam logic [7:0]  ADDR_IRQ_MASK              = 8'h24;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          DATA_W      = 16;
  localparam int          AUX_N       = 4;
  localparam int          CELL_N      = 14;
  localparam int          EVT_N       = 3;
  localparam logic [15:0] ALERT_RESET = 16'h0000;
  localparam logic [3:0]  AUX_EN_RESET  = 4'h0;
  localparam logic [13:0] CELL_EN_RESET = 14'h0000;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;

  // ---------------------------------------------------------------
  // interrupt event bit positions
  // ---------------------------------------------------------------
  localparam int EVT_AUX_UNDER  = 0;
  localparam int EVT_CELL_OVER  = 1;
  localparam int EVT_CELL_UNDER = 2;

  // ---------------------------------------------------------------
  // state of the top module and the interrupt block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  aux_en;
    logic [13:0] ov_en;
    logic [13:0] uv_en;
    logic [15:0] rdata;
  } fas_top_state_t;

  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
  } fas_irq_state_t;

endpackage

// ===== src/fas_irq_if.sv
`timescale 1ns/100ps
interface fas_irq_if;
  logic [2:0] evt;       // one-cycle event pulses
  logic       clr_wr;    // write one to clear status
  logic       mask_wr;   // write mask
  logic [2:0] wdata;
  logic [2:0] status;
  logic [2:0] mask;
  logic       irq;

  modport ctl (
    output evt,
    output clr_wr,
    output mask_wr,
    output wdata,
    input  status,
    input  mask,
    input  irq
  );

  modport irqs (
    input  evt,
    input  clr_wr,
    input  mask_wr,
    input  wdata,
    output status,
    output mask,
    output irq
  );
endinterface

// ===== src/fas_alert_core.sv
`timescale 1ns/100ps
module fas_alert_core #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         acq_i,
  input  wire logic [W-1:0] cond_i,
  input  wire logic [W-1:0] en_i,
  output logic      [W-1:0] flags_o,
  output logic              rise_o
);

  // ---------------------------------------------------------------
  // flag update at each acquisition
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] flags;
  } fas_core_state_t;

  fas_core_state_t s_q;
  fas_core_state_t s_d;

  // a set flag holds while its condition stays; new ones need enable
  always_comb begin
    s_d = s_q;
    if (acq_i) begin
      s_d.flags = cond_i & (en_i | s_q.flags);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // any flag newly raised in this cycle
  assign rise_o  = ce_i & |(s_d.flags & ~s_q.flags);
  assign flags_o = s_q.flags;

endmodule

// ===== src/fas_irq.sv
`timescale 1ns/100ps
module fas_irq (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  fas_irq_if.irqs   bus
);

  // ---------------------------------------------------------------
  // sticky status and mask
  // ---------------------------------------------------------------
  fas_pkg::fas_irq_state_t s_q;
  fas_pkg::fas_irq_state_t s_d;

  // set beats a clear landing in the same cycle
  always_comb begin
    s_d = s_q;
    if (bus.clr_wr) begin
      s_d.status = s_q.status & ~bus.wdata;
    end
    s_d.status = s_d.status | bus.evt;
    if (bus.mask_wr) begin
      s_d.mask = bus.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= {fas_pkg::IRQ_RESET, fas_pkg::IRQ_RESET};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign bus.status = s_q.status;
  assign bus.mask   = s_q.mask;
  assign bus.irq    = |(s_q.status & s_q.mask);

endmodule

// ===== src/fas_alert_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
// Function
// - four aux undervoltage flags, gated by enable
// - aux flag held until acquisition clears it
// - fourteen cell overvoltage flags, gated by enable
// - overvoltage flag clears only when resolved
// - overvoltage register, fourteen bits, reset zero
// - cell n sits in bit n-1
// - undervoltage register, fourteen bits, reset zero
module fas_alert_regs (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  input  wire logic        AUX_ACQ_DONE_I,
  input  wire logic        COMP_ACQ_DONE_I,
  input  wire logic [3:0]  AUX_UNDER_COND_I,
  input  wire logic [13:0] CELL_OVER_COND_I,
  input  wire logic [13:0] CELL_UNDER_COND_I,
  output logic             IRQ_O
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  fas_pkg::fas_top_state_t s_q;
  fas_pkg::fas_top_state_t s_d;

  logic [3:0]  aux_under_hot_flags;
  logic [13:0] comparator_cell_over_flags;
  logic [13:0] comparator_cell_under_flags;
  logic        aux_rise;
  logic        ov_rise;
  logic        uv_rise;

  fas_irq_if irq_bus ();

  // ---------------------------------------------------------------
  // alert flag engines
  // ---------------------------------------------------------------
  // aux undervoltage flags, updated per measurement acquisition
  fas_alert_core #(
    .W (fas_pkg::AUX_N)
  ) u_aux_under (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .acq_i   (AUX_ACQ_DONE_I),
    .cond_i  (AUX_UNDER_COND_I),
    .en_i    (s_q.aux_en),
    .flags_o (aux_under_hot_flags),
    .rise_o  (aux_rise)
  );

  // cell overvoltage flags, bit n-1 carries cell n
  fas_alert_core #(
    .W (fas_pkg::CELL_N)
  ) u_cell_over (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .acq_i   (COMP_ACQ_DONE_I),
    .cond_i  (CELL_OVER_COND_I),
    .en_i    (s_q.ov_en),
    .flags_o (comparator_cell_over_flags),
    .rise_o  (ov_rise)
  );

  // cell undervoltage flags from the comparator engine
  fas_alert_core #(
    .W (fas_pkg::CELL_N)
  ) u_cell_under (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .acq_i   (COMP_ACQ_DONE_I),
    .cond_i  (CELL_UNDER_COND_I),
    .en_i    (s_q.uv_en),
    .flags_o (comparator_cell_under_flags),
    .rise_o  (uv_rise)
  );

  // ---------------------------------------------------------------
  // interrupt block
  // ---------------------------------------------------------------
  // events and software writes toward the interrupt block
  assign irq_bus.evt     = {uv_rise, ov_rise, aux_rise};
  assign irq_bus.clr_wr  = CE_I & WR_I & hit(ADDR_I, fas_pkg::ADDR_IRQ_STATUS);
  assign irq_bus.mask_wr = CE_I & WR_I & hit(ADDR_I, fas_pkg::ADDR_IRQ_MASK);
  assign irq_bus.wdata   = WDATA_I[2:0];

  fas_irq u_irq (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .bus     (irq_bus.irqs)
  );

  // ---------------------------------------------------------------
  // register writes and read data
  // ---------------------------------------------------------------
  // only the enable and interrupt registers take writes; alert registers never do
  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    if (WR_I) begin
      if (hit(ADDR_I, fas_pkg::ADDR_AUX_UNDER_ALERT_EN)) begin
        s_d.aux_en = WDATA_I[3:0];
      end
      if (hit(ADDR_I, fas_pkg::ADDR_CELL_OVER_ALERT_EN)) begin
        s_d.ov_en = WDATA_I[13:0];
      end
      if (hit(ADDR_I, fas_pkg::ADDR_CELL_UNDER_ALERT_EN)) begin
        s_d.uv_en = WDATA_I[13:0];
      end
    end
    if (RD_I) begin
      unique case (ADDR_I)
        fas_pkg::ADDR_AUX_UNDER_HOT_ALERT: begin
          s_d.rdata = {12'h000, aux_under_hot_flags};
        end
        fas_pkg::ADDR_CMP_CELL_OVER_ALERT: begin
          s_d.rdata = {2'h0, comparator_cell_over_flags};
        end
        fas_pkg::ADDR_CMP_CELL_UNDER_ALERT: begin
          s_d.rdata = {2'h0, comparator_cell_under_flags};
        end
        fas_pkg::ADDR_AUX_UNDER_ALERT_EN: begin
          s_d.rdata = {12'h000, s_q.aux_en};
        end
        fas_pkg::ADDR_CELL_OVER_ALERT_EN: begin
          s_d.rdata = {2'h0, s_q.ov_en};
        end
        fas_pkg::ADDR_CELL_UNDER_ALERT_EN: begin
          s_d.rdata = {2'h0, s_q.uv_en};
        end
        fas_pkg::ADDR_IRQ_STATUS: begin
          s_d.rdata = {13'h0, irq_bus.status};
        end
        fas_pkg::ADDR_IRQ_MASK: begin
          s_d.rdata = {13'h0, irq_bus.mask};
        end
        default: begin
          s_d.rdata = '0;                                      // unmapped reads zero
        end
      endcase
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= {fas_pkg::AUX_EN_RESET, fas_pkg::CELL_EN_RESET,
              fas_pkg::CELL_EN_RESET, fas_pkg::ALERT_RESET};
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata;
  assign IRQ_O   = irq_bus.irq;

endmodule

// ===== bench/fas_alert_regs_assertions.sv
`timescale 1ns/100ps
module fas_chk (
  input wire logic        CORE_CLK_I,
  input wire logic        RESETN_I,
  input wire logic        CE_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic        RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic        AUX_ACQ_DONE_I,
  input wire logic        COMP_ACQ_DONE_I,
  input wire logic [3:0]  AUX_UNDER_COND_I,
  input wire logic [13:0] CELL_OVER_COND_I,
  input wire logic [13:0] CELL_UNDER_COND_I
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // ---------------------------------------------------------------
  // read decodes and acquisition steps
  // ---------------------------------------------------------------
  wire logic r_aux = RD_I && CE_I && ADDR_I == 8'h0d;
  wire logic r_ov  = RD_I && CE_I && ADDR_I == 8'h0e;
  wire logic r_uv  = RD_I && CE_I && ADDR_I == 8'h0f;
  sequence s_aacq; CE_I && AUX_ACQ_DONE_I ##1 !AUX_ACQ_DONE_I; endsequence
  sequence s_cacq; CE_I && COMP_ACQ_DONE_I ##1 !COMP_ACQ_DONE_I; endsequence
  sequence s_aux2; r_aux && !AUX_ACQ_DONE_I ##1 r_aux; endsequence
  sequence s_ov2; r_ov && !COMP_ACQ_DONE_I ##1 r_ov; endsequence
  property p_idle; CE_I && !RD_I |=> RDATA_O == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_ov_hi; r_ov |=> RDATA_O[15:14] == 2'h0; endproperty
  a_ov_hi: assert property (p_ov_hi) else $error("over upper bits set");
  property p_uv_hi; r_uv |=> RDATA_O[15:14] == 2'h0; endproperty
  a_uv_hi: assert property (p_uv_hi) else $error("under upper bits set");
  property p_aux_hold; s_aux2 |=> $stable(RDATA_O); endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux flags moved");
  property p_ov_hold; s_ov2 |=> $stable(RDATA_O); endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("over flags moved");
  property p_aux_sub;
    s_aacq ##1 r_aux |=> (RDATA_O[3:0] & ~$past(AUX_UNDER_COND_I, 3)) == 4'h0;
  endproperty
  a_aux_sub: assert property (p_aux_sub) else $error("aux flag without cause");
  property p_ov_sub;
    s_cacq ##1 r_ov |=> (RDATA_O[13:0] & ~$past(CELL_OVER_COND_I, 3)) == 14'h0;
  endproperty
  a_ov_sub: assert property (p_ov_sub) else $error("over flag without cause");
  property p_uv_sub;
    s_cacq ##1 r_uv |=> (RDATA_O[13:0] & ~$past(CELL_UNDER_COND_I, 3)) == 14'h0;
  endproperty
  a_uv_sub: assert property (p_uv_sub) else $error("under flag without cause");
endmodule
bind fas_alert_regs fas_chk u_chk (
  .CORE_CLK_I        (CORE_CLK_I),
  .RESETN_I          (RESETN_I),
  .CE_I              (CE_I),
  .ADDR_I            (ADDR_I),
  .RD_I              (RD_I),
  .RDATA_O           (RDATA_O),
  .AUX_ACQ_DONE_I    (AUX_ACQ_DONE_I),
  .COMP_ACQ_DONE_I   (COMP_ACQ_DONE_I),
  .AUX_UNDER_COND_I  (AUX_UNDER_COND_I),
  .CELL_OVER_COND_I  (CELL_OVER_COND_I),
  .CELL_UNDER_COND_I (CELL_UNDER_COND_I)
);

// ===== bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        aacq = 1'b0;
  logic        cacq = 1'b0;
  logic        ce = 1'b1;
  logic        irq;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [3:0]  acond = 4'h0;
  logic [13:0] ocond = 14'h0;
  logic [13:0] ucond = 14'h0;
  logic [13:0] f [3] = '{default: 14'h0};
  logic [13:0] e [3] = '{default: 14'h0};
  logic [2:0]  st = 3'h0;
  logic [2:0]  mk = 3'h0;
  logic [31:0] r;
  int          g;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  fas_alert_regs DUT (.CORE_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .AUX_ACQ_DONE_I(aacq),
    .COMP_ACQ_DONE_I(cacq), .AUX_UNDER_COND_I(acond), .CELL_OVER_COND_I(ocond),
    .CELL_UNDER_COND_I(ucond), .IRQ_O(irq));
  // ---------------------------------------------------------------
  // clock, watchdog, helpers
  // ---------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // flag update taken at an acquisition edge
  function automatic logic [13:0] nxt(input logic [13:0] c, input logic [13:0] en,
                                      input logic [13:0] old);
    return c & (en | old);
  endfunction
  task automatic wrt(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // n back-to-back reads of one index, each answer checked in its cycle
  task automatic rdc(input logic [7:0] a, input logic [15:0] x, input int n = 1);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      rd <= (i < n);
      #1 chk(rdata, x);
    end
  endtask
  // frz holds the clock enable low over the pulse, so nothing may change
  task automatic acq(input logic comp, input logic [13:0] a, input logic [13:0] o,
                     input logic [13:0] u, input logic frz = 1'b0);
    logic [13:0] c;
    @(posedge clk);
    ce <= !frz;
    acond <= a[3:0];
    ocond <= o;
    ucond <= u;
    aacq <= !comp;
    cacq <= comp;
    @(posedge clk);
    ce <= 1'b1;
    aacq <= 1'b0;
    cacq <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? (a & 14'h000f) : (k == 1) ? o : u;
      if ((k > 0) == comp && !frz) begin
        if ((nxt(c, e[k], f[k]) & ~f[k]) != 14'h0) st[k] = 1'b1;
        f[k] = nxt(c, e[k], f[k]);
      end
    end
  endtask
  task automatic check_all();
    for (int k = 0; k < 3; k++) begin
      rdc(8'(13 + k), {2'h0, f[k]}, 2);
      rdc(8'(32 + k), {2'h0, e[k]});
    end
    rdc(8'h23, {13'h0, st});
    chk({15'h0, irq}, {15'h0, |(st & mk)});
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    r = $urandom(32'h8e1397e4);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check_all();
    e[1] = 14'h3fff;
    wrt(8'h21, 16'h3fff);
    mk = 3'h7;
    wrt(8'h24, 16'h0007);
    acq(1'b1, 14'h0, 14'h2000, 14'h0);
    rdc(8'h0e, 16'h2000);
    wrt(8'h0e, 16'hffff);
    wrt(8'h0d, 16'hffff);
    rdc(8'h30, 16'h0000);
    check_all();
    repeat (80) begin
      r = $urandom;
      g = int'(r[1:0]) % 3;
      case (r[4:2])
        3'h0: begin
          e[g] = r[31:18] & ((g == 0) ? 14'h000f : 14'h3fff);
          wrt(8'(32 + g), {2'h0, e[g]});
        end
        3'h1: begin
          st = st & ~r[7:5];
          wrt(8'h23, {13'h0, r[7:5]});
        end
        3'h2: begin
          mk = r[7:5];
          wrt(8'h24, {13'h0, mk});
        end
        3'h3: acq(r[5], r[19:6], r[31:18], r[27:14], 1'b1);
        default: begin
          acq(r[5], r[19:6], r[31:18], r[27:14]);
          g = r[5] ? 1 + int'(r[6]) : 0;
          rdc(8'(13 + g), {2'h0, f[g]});
        end
      endcase
      check_all();
    end
    finish_test();
  end
endmodule
